/* File: hw/dmt_pkg.sv */
`default_nettype none
package dmt_pkg;
    // ==========================================
    // register addresses on the special-function register port
    localparam logic [7:0] ADDR_TIMER_CONTROL = 8'hC8;
    localparam logic [7:0] ADDR_RELOAD_LOW = 8'hCA;
    localparam logic [7:0] ADDR_RELOAD_HIGH = 8'hCB;
    localparam logic [7:0] ADDR_COUNT_LOW = 8'hCC;
    localparam logic [7:0] ADDR_COUNT_HIGH = 8'hCD;
    // ==========================================
    // timer_control bit positions
    localparam int BIT_OVF_HIGH = 7;
    localparam int BIT_OVF_LOW = 6;
    localparam int BIT_LOW_IRQ_EN = 5;
    localparam int BIT_OSC_CAP_EN = 4;
    localparam int BIT_SPLIT = 3;
    localparam int BIT_RUN = 2;
    localparam int BIT_CAP_SRC = 1;
    localparam int BIT_EXT_CLK = 0;
    // ==========================================
    // reset values and byte limits
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] RELOAD_RESET = 8'h00;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] BYTE_MAX = 8'hFF;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;
    // ==========================================
    // timebase divisors
    localparam int SYS_DIVIDE = 12;
    localparam int EXT_DIVIDE = 8;
endpackage
`default_nettype wire

/* File: hw/dmt_byte_cnt.sv */
`timescale 1ns/1ps
`default_nettype none
module dmt_byte_cnt (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic inc_i,
    input wire logic reload_en_i,
    input wire logic [7:0] reload_val_i,
    input wire logic wr_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] cnt_o,
    output logic wrap_o
);
    // ==========================================
    // one counter half
    logic [7:0] cnt_r;

    assign wrap_o = inc_i && (cnt_r == dmt_pkg::BYTE_MAX);
    assign cnt_o = cnt_r;

    // software write takes priority over counting
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cnt_r <= dmt_pkg::COUNT_RESET;
        end else if (wr_i) begin
            cnt_r <= wdata_i;
        end else if (wrap_o && reload_en_i) begin
            cnt_r <= reload_val_i;
        end else if (inc_i) begin
            cnt_r <= cnt_r + 8'h01;
        end
    end
endmodule
`default_nettype wire

/* File: hw/dmt_timer.sv */
// Overview of operation
// - high byte wrap sets high flag
// - 16-bit wrap sets high flag
// - high flag requests irq when enabled
// - hardware never clears either flag
// - low byte wrap always sets low flag
// - low flag requests irq if enabled
// - oscillator falling edge captures, requests irq
// - split mode gives two reloading halves
// - run bit gates 16-bit counting
// - split: run gates upper half only
// - capture source bit picks capture event
// - external select picks div12 or ext div8
// - per-half select picks core clock or timebase
// - low reload register, rw, resets zero
// - high reload register, rw, resets zero
// - 16-bit wrap loads reload pair
// - each half reloads from its own byte
// - capture latches count into reload pair
`timescale 1ns/1ps
`default_nettype none
module dmt_timer #(
    parameter int SYS_DIV = dmt_pkg::SYS_DIVIDE,
    parameter int EXT_DIV = dmt_pkg::EXT_DIVIDE
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic sfr_rd_i,
    output logic [7:0] sfr_rdata_o,
    input wire logic timer_irq_enable_i,
    input wire logic upper_half_clock_select_i,
    input wire logic lower_half_clock_select_i,
    input wire logic capture_mode_enable_i,
    input wire logic ext_clk_i,
    input wire logic usb_sof_i,
    input wire logic low_freq_osc_i,
    output logic irq_o
);
    // ==========================================
    // dividers are 8-bit counters
    if (SYS_DIV < 2 || SYS_DIV > 256 || EXT_DIV < 2 || EXT_DIV > 256) begin : g_div_check
        $error("divisor out of range");
    end

    // ==========================================
    // control register
    logic [7:0] ctrl_r;
    logic [7:0] reload_low_r;
    logic [7:0] reload_high_r;
    logic [7:0] cnt_low;
    logic [7:0] cnt_high;
    logic low_wrap;
    logic high_wrap;
    logic wr_ctrl;
    logic wr_rl_low;
    logic wr_rl_high;
    logic wr_cnt_low;
    logic wr_cnt_high;
    logic split_mode_enable;
    logic run_control;
    logic capture_source_select;
    logic external_clock_select;
    logic osc_capture_enable;
    logic low_byte_irq_enable;
    logic overflow_high_flag;
    logic overflow_low_flag;

    assign wr_ctrl = sfr_wr_i && (sfr_addr_i == dmt_pkg::ADDR_TIMER_CONTROL);
    assign wr_rl_low = sfr_wr_i && (sfr_addr_i == dmt_pkg::ADDR_RELOAD_LOW);
    assign wr_rl_high = sfr_wr_i && (sfr_addr_i == dmt_pkg::ADDR_RELOAD_HIGH);
    assign wr_cnt_low = sfr_wr_i && (sfr_addr_i == dmt_pkg::ADDR_COUNT_LOW);
    assign wr_cnt_high = sfr_wr_i && (sfr_addr_i == dmt_pkg::ADDR_COUNT_HIGH);
    assign split_mode_enable = ctrl_r[dmt_pkg::BIT_SPLIT];
    assign run_control = ctrl_r[dmt_pkg::BIT_RUN];
    assign capture_source_select = ctrl_r[dmt_pkg::BIT_CAP_SRC];
    assign external_clock_select = ctrl_r[dmt_pkg::BIT_EXT_CLK];
    assign osc_capture_enable = ctrl_r[dmt_pkg::BIT_OSC_CAP_EN];
    assign low_byte_irq_enable = ctrl_r[dmt_pkg::BIT_LOW_IRQ_EN];
    assign overflow_high_flag = ctrl_r[dmt_pkg::BIT_OVF_HIGH];
    assign overflow_low_flag = ctrl_r[dmt_pkg::BIT_OVF_LOW];

    // ==========================================
    // timebase dividers
    logic [7:0] sys_div_r;
    logic [7:0] ext_div_r;
    logic ext_prev_r;
    logic sys_tick;
    logic ext_edge;
    logic ext_tick;
    logic base_tick;
    logic low_tick;
    logic high_tick;

    assign sys_tick = (sys_div_r == 8'(SYS_DIV - 1));
    assign ext_edge = ext_clk_i && !ext_prev_r;
    assign ext_tick = ext_edge && (ext_div_r == 8'(EXT_DIV - 1));

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sys_div_r <= 8'h00;
        end else if (sys_tick) begin
            sys_div_r <= 8'h00;
        end else begin
            sys_div_r <= sys_div_r + 8'h01;
        end
    end

    // ext input counted on its rising edges, already in the core clock domain
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ext_prev_r <= 1'b0;
            ext_div_r <= 8'h00;
        end else begin
            ext_prev_r <= ext_clk_i;
            if (ext_tick) begin
                ext_div_r <= 8'h00;
            end else if (ext_edge) begin
                ext_div_r <= ext_div_r + 8'h01;
            end
        end
    end

    assign base_tick = external_clock_select ? ext_tick : sys_tick;
    assign low_tick = lower_half_clock_select_i ? 1'b1 : base_tick;
    assign high_tick = upper_half_clock_select_i ? 1'b1 : base_tick;

    // ==========================================
    // counter halves
    logic low_inc;
    logic high_inc;
    logic reload_ok;
    logic full_wrap;

    // run gates both halves when joined
    assign low_inc = split_mode_enable ? low_tick : (run_control && low_tick);
    assign high_inc = split_mode_enable ? (run_control && high_tick) : low_wrap;
    // capture mode counts through zero without reloading
    assign reload_ok = !capture_mode_enable_i;
    assign full_wrap = !split_mode_enable && high_wrap;

    // reload on wrap in 16-bit mode
    // each half reloads from own byte
    dmt_byte_cnt u_low (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .inc_i(low_inc),
        .reload_en_i(reload_ok && (split_mode_enable || cnt_high == dmt_pkg::BYTE_MAX)),
        .reload_val_i(reload_low_r),
        .wr_i(wr_cnt_low),
        .wdata_i(sfr_wdata_i),
        .cnt_o(cnt_low),
        .wrap_o(low_wrap)
    );

    dmt_byte_cnt u_high (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .inc_i(high_inc),
        .reload_en_i(reload_ok),
        .reload_val_i(reload_high_r),
        .wr_i(wr_cnt_high),
        .wdata_i(sfr_wdata_i),
        .cnt_o(cnt_high),
        .wrap_o(high_wrap)
    );

    // ==========================================
    // capture events
    logic lfo_prev_r;
    logic lfo_fall;
    logic capture;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            lfo_prev_r <= 1'b0;
        end else begin
            lfo_prev_r <= low_freq_osc_i;
        end
    end

    assign lfo_fall = lfo_prev_r && !low_freq_osc_i;
    // source chosen only in capture mode
    // 0 frame start, 1 oscillator edge
    // oscillator enable captures on its own
    assign capture = (capture_mode_enable_i &&
                      (capture_source_select ? lfo_fall : usb_sof_i)) ||
                     (osc_capture_enable && lfo_fall);

    // ==========================================
    // reload registers, capture beats a same-cycle write
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            reload_low_r <= dmt_pkg::RELOAD_RESET;
        end else if (capture) begin
            reload_low_r <= cnt_low;
        end else if (wr_rl_low) begin
            reload_low_r <= sfr_wdata_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            reload_high_r <= dmt_pkg::RELOAD_RESET;
        end else if (capture) begin
            reload_high_r <= cnt_high;
        end else if (wr_rl_high) begin
            reload_high_r <= sfr_wdata_i;
        end
    end

    // ==========================================
    // control register and flags
    logic [7:0] ctrl_nxt;

    always_comb begin
        ctrl_nxt = ctrl_r;
        if (wr_ctrl) begin
            ctrl_nxt = sfr_wdata_i;
        end
        // high byte wrap in either mode
        // capture also raises the high flag so it can interrupt
        if (high_wrap || capture) begin
            ctrl_nxt[dmt_pkg::BIT_OVF_HIGH] = 1'b1;
        end
        if (low_wrap) begin
            ctrl_nxt[dmt_pkg::BIT_OVF_LOW] = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ctrl_r <= dmt_pkg::CONTROL_RESET;
        end else begin
            ctrl_r <= ctrl_nxt;
        end
    end

    // ==========================================
    // interrupt request
    // high flag requests interrupt
    // low flag if low enable set
    assign irq_o = timer_irq_enable_i &&
                   (overflow_high_flag || (low_byte_irq_enable && overflow_low_flag));

    // ==========================================
    // read port, data one cycle after the strobe
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sfr_rdata_o <= dmt_pkg::READ_UNMAPPED;
        end else if (sfr_rd_i) begin
            unique case (sfr_addr_i)
                dmt_pkg::ADDR_TIMER_CONTROL: sfr_rdata_o <= ctrl_r;
                dmt_pkg::ADDR_RELOAD_LOW: sfr_rdata_o <= reload_low_r;
                dmt_pkg::ADDR_RELOAD_HIGH: sfr_rdata_o <= reload_high_r;
                dmt_pkg::ADDR_COUNT_LOW: sfr_rdata_o <= cnt_low;
                dmt_pkg::ADDR_COUNT_HIGH: sfr_rdata_o <= cnt_high;
                default: sfr_rdata_o <= dmt_pkg::READ_UNMAPPED;
            endcase
        end
    end

    // ==========================================
    // assertions
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    property p_high_flag_set;
        high_wrap |=> overflow_high_flag;
    endproperty
    a_high_flag_set: assert property (p_high_flag_set) else $error("high flag missed");

    property p_full_wrap_reload;
        (full_wrap && reload_ok && !wr_cnt_low && !wr_cnt_high) |=>
            (cnt_low == $past(reload_low_r)) && (cnt_high == $past(reload_high_r));
    endproperty
    a_full_wrap_reload: assert property (p_full_wrap_reload) else $error("no reload");

    property p_irq_high;
        (timer_irq_enable_i && overflow_high_flag) |-> irq_o;
    endproperty
    a_irq_high: assert property (p_irq_high) else $error("irq missing");

    property p_flag_hold;
        (overflow_low_flag && !wr_ctrl) |=> overflow_low_flag;
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag self-cleared");

    property p_low_flag_set;
        low_wrap |=> overflow_low_flag;
    endproperty
    a_low_flag_set: assert property (p_low_flag_set) else $error("low flag missed");

    property p_irq_low_masked;
        (!low_byte_irq_enable && !overflow_high_flag) |-> !irq_o;
    endproperty
    a_irq_low_masked: assert property (p_irq_low_masked) else $error("masked irq");

    property p_capture_copy;
        capture |=> (reload_low_r == $past(cnt_low)) && (reload_high_r == $past(cnt_high));
    endproperty
    a_capture_copy: assert property (p_capture_copy) else $error("capture lost");

    property p_stopped;
        (!run_control && !split_mode_enable && !wr_cnt_low && !wr_cnt_high) |=>
            $stable(cnt_low) && $stable(cnt_high);
    endproperty
    a_stopped: assert property (p_stopped) else $error("counted while stopped");

    property p_split_low_runs;
        (split_mode_enable && lower_half_clock_select_i && !wr_cnt_low &&
         cnt_low != dmt_pkg::BYTE_MAX) |=> cnt_low == $past(cnt_low) + 8'h01;
    endproperty
    a_split_low_runs: assert property (p_split_low_runs) else $error("low half idle");

    c_full_wrap: cover property (full_wrap && reload_ok);
    c_split_wraps: cover property (split_mode_enable && low_wrap ##[1:600] high_wrap);
    c_capture_lfo: cover property (capture && lfo_fall);
    c_irq: cover property (irq_o);
endmodule
`default_nettype wire

/* File: verif/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
    // ==========================================
    // signals and design
    logic clk_i, rst_n_i, sfr_wr_i, sfr_rd_i, irq_en, up_sel, lo_sel, cap_mode;
    logic ext_clk_i, usb_sof_i, low_freq_osc_i, irq_o;
    logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o, d;
    int num_errors = 0;
    int n_tests = 0;

    dmt_timer dut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i),
        .sfr_wdata_i(sfr_wdata_i), .sfr_rd_i(sfr_rd_i), .sfr_rdata_o(sfr_rdata_o),
        .timer_irq_enable_i(irq_en), .upper_half_clock_select_i(up_sel),
        .lower_half_clock_select_i(lo_sel), .capture_mode_enable_i(cap_mode),
        .ext_clk_i(ext_clk_i), .usb_sof_i(usb_sof_i), .low_freq_osc_i(low_freq_osc_i),
        .irq_o(irq_o)
    );

    // ==========================================
    // clocks: ext clock rises every 4 core cycles
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    initial begin
        ext_clk_i = 1'b0;
        forever #100 ext_clk_i = ~ext_clk_i;
    end

    // ==========================================
    // access tasks and compares
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge clk_i);
        sfr_addr_i = a;
        sfr_wdata_i = v;
        sfr_wr_i = 1'b1;
        @(negedge clk_i);
        sfr_wr_i = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(negedge clk_i);
        sfr_addr_i = a;
        sfr_rd_i = 1'b1;
        @(negedge clk_i);
        sfr_rd_i = 1'b0;
        d = sfr_rdata_o;
    endtask

    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask

    // range compare, for counts whose divider phase is free
    task automatic chk_rng(input string n, input logic [7:0] lo, input logic [7:0] hi);
        n_tests++;
        if (!(d >= lo && d <= hi) || $isunknown(d)) begin
            num_errors++;
            $display("[FAIL] %s expected %h..%h seen %h", n, lo, hi, d);
        end
    endtask

    task automatic rchk(input string n, input logic [7:0] a, input logic [7:0] e);
        rd(a);
        chk(n, e, d);
    endtask

    task automatic chk_irq(input logic e);
        @(negedge clk_i);
        chk("irq_o", {7'h00, e}, {7'h00, irq_o});
    endtask

    task automatic pulse_sof();
        @(negedge clk_i);
        usb_sof_i = 1'b1;
        @(negedge clk_i);
        usb_sof_i = 1'b0;
    endtask

    task automatic lfo_fall();
        @(negedge clk_i);
        low_freq_osc_i = 1'b1;
        repeat (2) @(negedge clk_i);
        low_freq_osc_i = 1'b0;
        @(negedge clk_i);
    endtask

    task automatic end_of_test();
        if (num_errors == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ==========================================
    // watchdog: tests need well under 3000 cycles
    initial begin
        #(50 * 20000);
        num_errors++;
        end_of_test();
    end

    // ==========================================
    // tests
    initial begin
        rst_n_i = 1'b0;
        {sfr_wr_i, sfr_rd_i, usb_sof_i, low_freq_osc_i, cap_mode, up_sel} = '0;
        sfr_addr_i = 8'h00;
        sfr_wdata_i = 8'h00;
        irq_en = 1'b1;
        lo_sel = 1'b1;
        repeat (4) @(negedge clk_i);
        rst_n_i = 1'b1;
        rchk("reload_low", dmt_pkg::ADDR_RELOAD_LOW, 8'h00);
        rchk("reload_high", dmt_pkg::ADDR_RELOAD_HIGH, 8'h00);
        rchk("control", dmt_pkg::ADDR_TIMER_CONTROL, 8'h00);
        rchk("unmapped", 8'hC9, dmt_pkg::READ_UNMAPPED);
        chk_irq(1'b0);
        // 16-bit wrap reloads pair, sets both flags
        wr(dmt_pkg::ADDR_COUNT_LOW, 8'hFD);
        wr(dmt_pkg::ADDR_COUNT_HIGH, 8'hFF);
        wr(dmt_pkg::ADDR_RELOAD_LOW, 8'h34);
        wr(dmt_pkg::ADDR_RELOAD_HIGH, 8'h12);
        rchk("reload_low", dmt_pkg::ADDR_RELOAD_LOW, 8'h34);
        rchk("reload_high", dmt_pkg::ADDR_RELOAD_HIGH, 8'h12);
        rchk("count_stopped", dmt_pkg::ADDR_COUNT_LOW, 8'hFD);
        wr(dmt_pkg::ADDR_TIMER_CONTROL, 8'h04);
        repeat (6) @(negedge clk_i);
        rchk("count_high", dmt_pkg::ADDR_COUNT_HIGH, 8'h12);
        rchk("flags", dmt_pkg::ADDR_TIMER_CONTROL, 8'hC4);
        chk_irq(1'b1);
        irq_en = 1'b0;
        chk_irq(1'b0);
        irq_en = 1'b1;
        repeat (50) @(negedge clk_i);
        rchk("flags_held", dmt_pkg::ADDR_TIMER_CONTROL, 8'hC4);
        wr(dmt_pkg::ADDR_TIMER_CONTROL, 8'h04);
        rchk("flags_clr", dmt_pkg::ADDR_TIMER_CONTROL, 8'h04);
        wr(dmt_pkg::ADDR_TIMER_CONTROL, 8'h84);
        rchk("flag_set", dmt_pkg::ADDR_TIMER_CONTROL, 8'h84);
        // low byte irq gating
        wr(dmt_pkg::ADDR_TIMER_CONTROL, 8'h24);
        wr(dmt_pkg::ADDR_COUNT_HIGH, 8'h00);
        wr(dmt_pkg::ADDR_COUNT_LOW, 8'hFE);
        repeat (4) @(negedge clk_i);
        rchk("low_flag", dmt_pkg::ADDR_TIMER_CONTROL, 8'h64);
        chk_irq(1'b1);
        wr(dmt_pkg::ADDR_TIMER_CONTROL, 8'h44);
        chk_irq(1'b0);
        // split mode: run off, only lower half counts; run on, upper half wraps and reloads too
        up_sel = 1'b1;
        wr(dmt_pkg::ADDR_TIMER_CONTROL, 8'h08);
        wr(dmt_pkg::ADDR_RELOAD_LOW, 8'hF0);
        wr(dmt_pkg::ADDR_RELOAD_HIGH, 8'h00);
        wr(dmt_pkg::ADDR_COUNT_HIGH, 8'h10);
        wr(dmt_pkg::ADDR_COUNT_LOW, 8'hFE);
        repeat (6) @(negedge clk_i);
        rchk("upper_gated", dmt_pkg::ADDR_COUNT_HIGH, 8'h10);
        rchk("split_flags", dmt_pkg::ADDR_TIMER_CONTROL, 8'h48);
        rd(dmt_pkg::ADDR_COUNT_LOW);
        chk_rng("low_reload", 8'hF0, 8'hFF);
        wr(dmt_pkg::ADDR_COUNT_HIGH, 8'hFE);
        wr(dmt_pkg::ADDR_TIMER_CONTROL, 8'h0C);
        repeat (4) @(negedge clk_i);
        rd(dmt_pkg::ADDR_TIMER_CONTROL);
        chk("high_flag", 8'h8C, d & 8'hBF);
        rd(dmt_pkg::ADDR_COUNT_HIGH);
        chk_rng("high_reload", 8'h00, 8'h08);
        // capture, counters stopped in 16-bit mode
        up_sel = 1'b0;
        cap_mode = 1'b1;
        wr(dmt_pkg::ADDR_TIMER_CONTROL, 8'h00);
        wr(dmt_pkg::ADDR_COUNT_LOW, 8'h78);
        wr(dmt_pkg::ADDR_COUNT_HIGH, 8'h56);
        pulse_sof();
        rchk("cap_low", dmt_pkg::ADDR_RELOAD_LOW, 8'h78);
        rchk("cap_high", dmt_pkg::ADDR_RELOAD_HIGH, 8'h56);
        rchk("cap_flag", dmt_pkg::ADDR_TIMER_CONTROL, 8'h80);
        wr(dmt_pkg::ADDR_TIMER_CONTROL, 8'h02);
        wr(dmt_pkg::ADDR_COUNT_LOW, 8'h9A);
        pulse_sof();
        rchk("sof_ignored", dmt_pkg::ADDR_RELOAD_LOW, 8'h78);
        lfo_fall();
        rchk("lfo_cap", dmt_pkg::ADDR_RELOAD_LOW, 8'h9A);
        // capture mode counts through zero, reload pair untouched
        wr(dmt_pkg::ADDR_COUNT_LOW, 8'hFF);
        wr(dmt_pkg::ADDR_COUNT_HIGH, 8'hFF);
        wr(dmt_pkg::ADDR_TIMER_CONTROL, 8'h06);
        rchk("cap_no_reload", dmt_pkg::ADDR_COUNT_HIGH, 8'h00);
        rchk("cap_wrap_flags", dmt_pkg::ADDR_TIMER_CONTROL, 8'hC6);
        cap_mode = 1'b0;
        wr(dmt_pkg::ADDR_TIMER_CONTROL, 8'h10);
        wr(dmt_pkg::ADDR_COUNT_LOW, 8'hBC);
        lfo_fall();
        rchk("osc_cap", dmt_pkg::ADDR_RELOAD_LOW, 8'hBC);
        chk_irq(1'b1);
        // timebases: core/12, then ext/8
        lo_sel = 1'b0;
        wr(dmt_pkg::ADDR_TIMER_CONTROL, 8'h00);
        wr(dmt_pkg::ADDR_COUNT_LOW, 8'h00);
        wr(dmt_pkg::ADDR_TIMER_CONTROL, 8'h04);
        repeat (120) @(negedge clk_i);
        rd(dmt_pkg::ADDR_COUNT_LOW);
        chk_rng("div12", 8'h08, 8'h0C);
        wr(dmt_pkg::ADDR_TIMER_CONTROL, 8'h00);
        wr(dmt_pkg::ADDR_COUNT_LOW, 8'h00);
        wr(dmt_pkg::ADDR_TIMER_CONTROL, 8'h05);
        repeat (320) @(negedge clk_i);
        rd(dmt_pkg::ADDR_COUNT_LOW);
        chk_rng("ext_div8", 8'h08, 8'h0C);
        // per-half select: upper on core clock, lower on /12
        wr(dmt_pkg::ADDR_TIMER_CONTROL, 8'h08);
        wr(dmt_pkg::ADDR_COUNT_HIGH, 8'h00);
        wr(dmt_pkg::ADDR_COUNT_LOW, 8'h00);
        up_sel = 1'b1;
        wr(dmt_pkg::ADDR_TIMER_CONTROL, 8'h0C);
        repeat (24) @(negedge clk_i);
        rd(dmt_pkg::ADDR_COUNT_HIGH);
        chk_rng("upper_fast", 8'h18, 8'h22);
        rd(dmt_pkg::ADDR_COUNT_LOW);
        chk_rng("lower_slow", 8'h00, 8'h04);
        end_of_test();
    end
endmodule
`default_nettype wire
